//--- logic/uib_pkg.sv
package uib_pkg;
   // ==========================================
   // Register byte addresses
   localparam logic [3:0] ADDR_IRQ_EN = 4'h0;
   localparam logic [3:0] ADDR_DIV_LO = 4'h4;
   localparam logic [3:0] ADDR_DIV_HI = 4'h8;
   localparam logic [3:0] ADDR_SCRATCH = 4'hC;
   localparam logic [5:0] ADDR_CFG = 6'h10;
   localparam logic [5:0] ADDR_STATUS = 6'h14;
   localparam logic [5:0] ADDR_MASK = 6'h18;
   // ==========================================
   // Field positions
   localparam int RX_READY_BIT = 0;
   localparam int TX_EMPTY_BIT = 1;
   localparam int LINE_STATUS_BIT = 2;
   localparam int HANDSHAKE_BIT = 3;
   localparam int RX_ADDR_BIT = 6;
   localparam int TX_ADDR_BIT = 7;
   localparam int NINEBIT_BIT = 0;
   localparam int PREDIV_BIT = 1;
   localparam int HS_LO_BIT = 6;
   localparam int HS_HI_BIT = 7;
   // ==========================================
   // Reset values and dividers
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] DIV_LO_RST = 8'h01;
   localparam logic [7:0] DIV_HI_RST = 8'h00;
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam logic [3:0] STATUS_RST = 4'h0;
   localparam logic [3:0] PREDIV_NORMAL = 4'hD;
   localparam logic [7:0] IRQ_EN_WMASK = 8'hCF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uib_pkg

//--- logic/uib_top.sv
// Function
// - Handshake interrupt passes only while enable bit 3 is one.
// - Line status interrupt passes only while enable bit 2 is one.
// - Transmit empty interrupt passes only while enable bit 1 is one.
// - Receive ready interrupt passes only while enable bit 0 is one.
// - Enable bits 0 to 3 all zero means no port interrupt.
// - In 9-bit mode bit 7 selects address or data byte to send.
// - In 9-bit mode bit 6 selects receiving address or data bytes.
// - Divisor is formed from two 8-bit read/write registers.
// - Normal speed pre-divides reference by 13, then by divisor.
// - Generator output is 16x baud, base clock for tx and rx.
// - High-speed select applies divisor directly to the reference.
// - Pre-divider choice comes from a first-port configuration bit.
// - Scratch register reads back freely with no side effect.
`timescale 1ns/1ns
`default_nettype none
module uib_top #(
   parameter int DIV_WIDTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ref_clk_tick,
   input wire logic [3:0] irq_src,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic port_irq,
   output logic event_irq,
   output logic baud16_tick,
   output logic ninebit_enable,
   output logic tx_send_address,
   output logic rx_take_address
);
   // ==========================================
   // Registers
   logic [7:0] irq_en_q;
   logic [7:0] div_lo_q;
   logic [7:0] div_hi_q;
   logic [7:0] scratch_q;
   logic [7:0] cfg_q;
   logic [3:0] status_q;
   logic [3:0] mask_q;
   // Bus capture
   logic [5:0] awaddr_q;
   logic aw_have_q;
   logic [31:0] wdata_q;
   logic w_have_q;
   // Synchronisers and edge detectors
   logic [3:0] src_meta_q;
   logic [3:0] src_sync_q;
   logic [3:0] src_prev_q;
   logic tick_meta_q;
   logic tick_sync_q;
   logic tick_prev_q;
   // Baud generator state
   logic [3:0] pre_cnt_q;
   logic [DIV_WIDTH-1:0] div_cnt_q;
   logic baud16_q;
   // Decodes
   logic do_write;
   logic wr_bad;
   logic wr_hit;
   logic [3:0] gated_src;
   logic [3:0] rise;
   logic ref_edge;
   logic pre_wrap;
   logic prediv_on;
   logic pre_tick;
   logic [DIV_WIDTH-1:0] divisor;
   logic high_speed;

   // ==========================================
   // Elaboration checks
   // The divisor is exactly two byte registers, so no other width fits
   if (DIV_WIDTH != 16)
   begin : g_div_width_chk
      $error("uib_top needs DIV_WIDTH of 16");
   end
   // A pre-divide ratio below two leaves the counter nothing to count
   if (uib_pkg::PREDIV_NORMAL < 4'h2)
   begin : g_prediv_chk
      $error("uib_top needs a pre-divide ratio of at least 2");
   end

   // ==========================================
   // Write channel capture; address and data may arrive in either order
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
   // Unaligned or beyond the last register: error answer and no effect
   assign wr_bad = awaddr_q[1:0] != 2'h0 || awaddr_q > uib_pkg::ADDR_MASK;
   assign wr_hit = do_write && !wr_bad;

   // Address holder; freed once the pair has been consumed
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_have_q <= 1'b0;
         awaddr_q <= 6'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
         aw_have_q <= 1'b0;
   end

   // Data holder; lanes without strobe are zeroed on capture
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         w_have_q <= 1'b0;
         wdata_q <= 32'h00000000;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end
      else if (do_write)
         w_have_q <= 1'b0;
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= uib_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_bad ? uib_pkg::RESP_SLVERR : uib_pkg::RESP_OKAY;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ==========================================
   // Register file; every hit except STATUS writes its register from the masked data,
   // so a register whose byte lane had no strobe is written with zero
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq_en_q <= uib_pkg::IRQ_EN_RST;
         div_lo_q <= uib_pkg::DIV_LO_RST;
         div_hi_q <= uib_pkg::DIV_HI_RST;
         scratch_q <= uib_pkg::SCRATCH_RST;
         cfg_q <= uib_pkg::CFG_RST;
         mask_q <= uib_pkg::MASK_RST;
      end
      else if (wr_hit)
      begin
         case (awaddr_q)
            {2'h0, uib_pkg::ADDR_IRQ_EN}: irq_en_q <= wdata_q[7:0] & uib_pkg::IRQ_EN_WMASK;
            {2'h0, uib_pkg::ADDR_DIV_LO}: div_lo_q <= wdata_q[7:0];
            {2'h0, uib_pkg::ADDR_DIV_HI}: div_hi_q <= wdata_q[7:0];
            {2'h0, uib_pkg::ADDR_SCRATCH}: scratch_q <= wdata_q[7:0];
            uib_pkg::ADDR_CFG: cfg_q <= wdata_q[7:0];
            uib_pkg::ADDR_MASK: mask_q <= wdata_q[3:0];
            // Status and unmapped words are not stored here
            default: mask_q <= mask_q;
         endcase
      end
   end

   // ==========================================
   // Read channel; one-cycle latency, unmapped reads give SLVERR
   assign s_axi_arready = !s_axi_rvalid;

   // Read data registered, so the decode settles within one cycle
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= uib_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= uib_pkg::RESP_OKAY;
         case (s_axi_araddr)
            {2'h0, uib_pkg::ADDR_IRQ_EN}: s_axi_rdata <= {24'h000000, irq_en_q};
            {2'h0, uib_pkg::ADDR_DIV_LO}: s_axi_rdata <= {24'h000000, div_lo_q};
            {2'h0, uib_pkg::ADDR_DIV_HI}: s_axi_rdata <= {24'h000000, div_hi_q};
            {2'h0, uib_pkg::ADDR_SCRATCH}: s_axi_rdata <= {24'h000000, scratch_q};
            uib_pkg::ADDR_CFG: s_axi_rdata <= {24'h000000, cfg_q};
            uib_pkg::ADDR_STATUS: s_axi_rdata <= {28'h0000000, status_q};
            uib_pkg::ADDR_MASK: s_axi_rdata <= {28'h0000000, mask_q};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= uib_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ==========================================
   // Source synchronisers; sources come from other logic that may be async
   // Sources must hold for two cycles; shorter pulses may be missed
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         src_meta_q <= 4'h0;
         src_sync_q <= 4'h0;
         src_prev_q <= 4'h0;
         tick_meta_q <= 1'b0;
         tick_sync_q <= 1'b0;
         tick_prev_q <= 1'b0;
      end
      else
      begin
         src_meta_q <= irq_src;
         src_sync_q <= src_meta_q;
         src_prev_q <= src_sync_q;
         tick_meta_q <= ref_clk_tick;
         tick_sync_q <= tick_meta_q;
         tick_prev_q <= tick_sync_q;
      end
   end

   // ==========================================
   // Enable gating of the four interrupt sources
   // Enable gate for all four sources
   assign gated_src = src_sync_q & irq_en_q[3:0];
   assign port_irq = |gated_src;

   // Sticky events on rising enabled sources; set wins over write-one clear
   assign rise = gated_src & ~src_prev_q;

   // Write-one clear; an edge in the clearing cycle survives
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         status_q <= uib_pkg::STATUS_RST;
      else if (wr_hit && awaddr_q == uib_pkg::ADDR_STATUS)
         status_q <= (status_q & ~wdata_q[3:0]) | rise;
      else
         status_q <= status_q | rise;
   end

   // Event interrupt from masked status, apart from the port interrupt
   assign event_irq = |(status_q & mask_q);

   // ==========================================
   // 9-bit controls routed to the external engine
   assign ninebit_enable = cfg_q[uib_pkg::NINEBIT_BIT];
   assign tx_send_address = ninebit_enable & irq_en_q[uib_pkg::TX_ADDR_BIT];
   assign rx_take_address = ninebit_enable & irq_en_q[uib_pkg::RX_ADDR_BIT];

   // ==========================================
   // Baud generator, stepped by edges of the synchronised reference tick
   assign ref_edge = tick_sync_q & ~tick_prev_q;
   assign high_speed = cfg_q[uib_pkg::HS_HI_BIT] & cfg_q[uib_pkg::HS_LO_BIT];
   assign divisor = {div_hi_q, div_lo_q};

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         pre_cnt_q <= 4'h0;
      else if (ref_edge)
         pre_cnt_q <= pre_wrap ? 4'h0 : pre_cnt_q + 4'h1;
   end

   // Counter runs free, so a pre-divider switch costs one short period at most
   assign pre_wrap = pre_cnt_q >= uib_pkg::PREDIV_NORMAL - 4'h1;
   assign prediv_on = cfg_q[uib_pkg::PREDIV_BIT] && !high_speed;
   // Without the pre-divider every reference edge counts
   assign pre_tick = ref_edge && (!prediv_on || pre_wrap);

   // 16x tick out
   // A zero divisor is treated as one so the tick never stalls
   // Comparing with >= lets a smaller divisor take effect at once
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_cnt_q <= '0;
         baud16_q <= 1'b0;
      end
      else if (pre_tick)
      begin
         if (div_cnt_q + DIV_WIDTH'(1) >= divisor)
         begin
            div_cnt_q <= '0;
            baud16_q <= 1'b1;
         end
         else
         begin
            div_cnt_q <= div_cnt_q + DIV_WIDTH'(1);
            baud16_q <= 1'b0;
         end
      end
      else
         baud16_q <= 1'b0;
   end

   assign baud16_tick = baud16_q;
endmodule : uib_top
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] src = 4'h0;
   logic [3:0] irq_src, s_axi_wstrb = 4'hF;
   logic ref_clk_tick, port_irq, event_irq, baud16_tick;
   logic ninebit_enable, tx_send_address, rx_take_address;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_count = 0, checked = 0, cyc = 0;
   always #10 mclk = ~mclk;
   uib_top u_dut (.*);
   uib_far u_far (.mclk(mclk), .run(rst_b), .src_in(src), .ref_clk_tick(ref_clk_tick),
      .irq_src(irq_src));
   // ==========================================
   // Shared tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask : chk
   // Handshakes are read mid-cycle, so they match what the rising edge sees
   task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic aw, w, b;
      logic [1:0] rs;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(negedge mclk);
         aw = s_axi_awready & s_axi_awvalid;
         w = s_axi_wready & s_axi_wvalid;
         b = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge mclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end
      while (!b);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, rs});
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic ar, r;
      logic [31:0] dt;
      logic [1:0] rs;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(negedge mclk);
         ar = s_axi_arready & s_axi_arvalid;
         r = s_axi_rvalid;
         dt = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge mclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      while (!r);
      s_axi_rready <= 1'b0;
      chk("rdata", e, dt);
      chk("rresp", {30'h0, er}, {30'h0, rs});
   endtask : rd
   // Skip two ticks so a divisor change has settled, then time one period
   task automatic per(input int e);
      int n;
      repeat (2) @(posedge baud16_tick);
      @(negedge mclk);
      n = 0;
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (baud16_tick !== 1'b1);
      chk("period", 32'(e), 32'(n));
   endtask : per
   task automatic wrap_up;
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up
   // Longest run is three slow periods, well under this ceiling
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         err_count++;
         wrap_up();
      end
   end
   // ==========================================
   // Main sequence
   initial
   begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      rd(6'h04, 32'h01);
      rd(6'h08, 32'h00);
      wr(6'h0C, 8'hA5);
      rd(6'h0C, 32'hA5);
      rd(6'h00, 32'h00);
      wr(6'h00, 8'hFF);
      rd(6'h00, 32'hCF);
      for (int i = 0; i < 4; i++)
      begin
         wr(6'h00, 8'h01 << i);
         src <= ~(4'h1 << i);
         repeat (5) @(posedge mclk);
         chk("irq_off", 32'h0, port_irq);
         src <= 4'h1 << i;
         repeat (5) @(posedge mclk);
         chk("irq_on", 32'h1, port_irq);
      end
      wr(6'h00, 8'hC0);
      src <= 4'hF;
      repeat (5) @(posedge mclk);
      chk("irq_none", 32'h0, port_irq);
      wr(6'h10, 8'h01);
      chk("ninebit", 32'h1, ninebit_enable);
      rd(6'h10, 32'h01);
      chk("tx_addr", 32'h1, tx_send_address);
      chk("rx_addr", 32'h1, rx_take_address);
      wr(6'h00, 8'h80);
      chk("rx_data", 32'h0, rx_take_address);
      wr(6'h10, 8'h00);
      chk("tx_plain", 32'h0, tx_send_address);
      wr(6'h14, 8'h0F);
      wr(6'h18, 8'h01);
      rd(6'h18, 32'h01);
      wr(6'h00, 8'h01);
      src <= 4'h0;
      repeat (5) @(posedge mclk);
      src <= 4'h1;
      repeat (5) @(posedge mclk);
      rd(6'h14, 32'h01);
      chk("event_on", 32'h1, event_irq);
      wr(6'h18, 8'h00);
      chk("event_off", 32'h0, event_irq);
      wr(6'h14, 8'h01);
      rd(6'h14, 32'h00);
      wr(6'h10, 8'h02);
      per(52);
      wr(6'h04, 8'h03);
      wr(6'h10, 8'h00);
      per(12);
      wr(6'h10, 8'hC2);
      per(12);
      wr(6'h10, 8'h82);
      per(156);
      wr(6'h04, 8'h02);
      wr(6'h08, 8'h01);
      rd(6'h08, 32'h01);
      wr(6'h10, 8'h02);
      per(13416);
      wr(6'h1C, 8'h55, 2'h2);
      rd(6'h1C, 32'h0, 2'h2);
      wr(6'h05, 8'h77, 2'h2);
      rd(6'h05, 32'h0, 2'h2);
      rd(6'h04, 32'h02);
      s_axi_wstrb <= 4'hE;
      wr(6'h0C, 8'h5A);
      rd(6'h0C, 32'h00);
      s_axi_wstrb <= 4'hF;
      wrap_up();
   end
endmodule : testbench
`default_nettype wire

//--- sim/uib_checker.sv
`timescale 1ns/1ns
`default_nettype none
module uib_checker (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [3:0] irq_src,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic port_irq,
   input wire logic baud16_tick,
   input wire logic ninebit_enable,
   input wire logic tx_send_address,
   input wire logic rx_take_address
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // ==========================================
   // Interrupt and mode outputs
   property p_irq;
      port_irq |-> |($past(irq_src, 2) | $past(irq_src, 3));
   endproperty
   a_irq: assert property (p_irq) else $error("irq without source");
   property p_tx;
      tx_send_address |-> ninebit_enable;
   endproperty
   a_tx: assert property (p_tx) else $error("tx address off mode");
   property p_rx;
      rx_take_address |-> ninebit_enable;
   endproperty
   a_rx: assert property (p_rx) else $error("rx address off mode");
   // Tick must be a single-cycle pulse for the shifters
   property p_tick;
      baud16_tick |=> !baud16_tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick too long");
   // ==========================================
   // Register bus answers
   property p_bval;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_bval: assert property (p_bval) else $error("no write answer");
   property p_bdone;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_bdone: assert property (p_bdone) else $error("write answer stuck");
   property p_rval;
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
   endproperty
   a_rval: assert property (p_rval) else $error("no read answer");
   property p_arblk;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_arblk: assert property (p_arblk) else $error("read taken early");
endmodule : uib_checker
bind uib_top uib_checker u_chk (.*);
`default_nettype wire

//--- sim/uib_far.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Far side: reference clock and interrupt sources
module uib_far (
   input wire logic mclk,
   input wire logic run,
   input wire logic [3:0] src_in,
   output logic ref_clk_tick,
   output logic [3:0] irq_src
);
   logic [1:0] cnt_q = 2'h0;
   // Slow reference, four mclk a period, so no edge slips past the synchroniser
   always_ff @(posedge mclk)
   begin
      cnt_q <= run ? cnt_q + 2'h1 : 2'h0;
   end
   assign ref_clk_tick = cnt_q[1];
   assign irq_src = src_in;
endmodule : uib_far
`default_nettype wire
